// ### src/lcs_consts.svh
// timings in microseconds, indicator positions and defaults for the light curtain logic
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH

`define LCS_CLK_MHZ 100
`define LCS_NBEAMS 16
`define LCS_SYNC_US 1000
`define LCS_CAL_US 2000
`define LCS_CFM_US 300000
`define LCS_BLINK_US 250000
`define LCS_CODE_ILLEGAL 2'h3
`define LCS_LED_FUNC_CFM 0
`define LCS_LED_FUNC_WEAK 1
`define LCS_LED_FUNC_CODE 2
`define LCS_LED_CAUSE_CFM 4
`define LCS_LED_CAUSE_WEAK 5
`define LCS_LED_CAUSE_CODE 6

`endif

// ### src/lcs_pkg.sv
// types shared by the light curtain logic
package lcs_pkg;
    typedef enum logic [2:0] {
        LCS_ST_SYNC = 3'b000,
        LCS_ST_CAL = 3'b001,
        LCS_ST_RUN = 3'b010,
        LCS_ST_LOCK = 3'b011,
        LCS_ST_FAULT = 3'b100
    } lcs_state_t;
    typedef enum logic [1:0] {
        LCS_CODE_NONE = 2'b00,
        LCS_CODE_ONE = 2'b01,
        LCS_CODE_TWO = 2'b10
    } lcs_code_t;
    typedef enum logic [1:0] {
        LCS_DIAG_RESET_REQ = 2'b00,
        LCS_DIAG_WEAK = 2'b01,
        LCS_DIAG_FAULT = 2'b10,
        LCS_DIAG_INTERRUPT = 2'b11
    } lcs_diag_sel_t;
endpackage

// ### src/lcs_beam_eval.sv
// per-beam evaluation: code check, field clear, sync beams, alignment level
`timescale 1ns/1ps
`default_nettype none

module lcs_beam_eval #(
    parameter int unsigned NBEAMS = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [NBEAMS-1:0] i_beam_light,
    input wire logic [2*NBEAMS-1:0] i_beam_code,
    input wire logic [1:0] i_cfg_code,
    output logic [NBEAMS-1:0] o_beam_ok,
    output logic o_field_clear,
    output logic o_top_ok,
    output logic o_bot_ok,
    output logic [3:0] o_align
);
    localparam int unsigned CW = $clog2(NBEAMS + 1);
    localparam logic [CW+1:0] TH_HI = (CW+2)'(3 * NBEAMS);
    localparam logic [CW+1:0] TH_MID = (CW+2)'(2 * NBEAMS);

    logic [NBEAMS-1:0] ok_w;
    logic [CW-1:0] cnt_w;
    logic [CW+1:0] cnt4_w;
    logic [3:0] align_w;

    // a beam counts only if lit and carrying the configured code
    for (genvar k = 0; k < NBEAMS; k++) begin : g_beam
        assign ok_w[k] = i_beam_light[k] && (i_beam_code[2*k +: 2] == i_cfg_code);
    end

    always_comb begin
        cnt_w = '0;
        for (int j = 0; j < NBEAMS; j++) begin
            cnt_w = cnt_w + CW'(ok_w[j]);
        end
    end

    assign cnt4_w = {cnt_w, 2'b00};
    // more lit beams, more lit indicators
    assign align_w = (cnt_w == '0) ? 4'h0 :
                     (cnt_w == CW'(NBEAMS)) ? 4'hf :
                     (cnt4_w >= TH_HI) ? 4'h7 :
                     (cnt4_w >= TH_MID) ? 4'h3 : 4'h1;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_beam_ok <= '0;
            o_field_clear <= 1'b0;
            o_top_ok <= 1'b0;
            o_bot_ok <= 1'b0;
            o_align <= 4'h0;
        end else begin
            o_beam_ok <= ok_w;
            o_field_clear <= &ok_w;
            o_top_ok <= ok_w[NBEAMS-1];
            o_bot_ok <= ok_w[0];
            o_align <= align_w;
        end
    end

    AST_CODE_MISMATCH: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_beam_code[1:0] != i_cfg_code) |=> (!o_beam_ok[0] && !o_field_clear))
        else $error("mismatched code beam not treated as interrupted");

endmodule
`default_nettype wire

// ### src/lcs_top.sv
// receiver supervisory logic of the safety light curtain
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.svh"

module lcs_top #(
    parameter int unsigned NBEAMS = `LCS_NBEAMS,
    parameter int unsigned SYNC_CYC = `LCS_SYNC_US * `LCS_CLK_MHZ,
    parameter int unsigned CAL_CYC = `LCS_CAL_US * `LCS_CLK_MHZ,
    parameter int unsigned CFM_CYC = `LCS_CFM_US * `LCS_CLK_MHZ,
    parameter int unsigned BLINK_CYC = `LCS_BLINK_US * `LCS_CLK_MHZ
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [NBEAMS-1:0] i_beam_light,
    input wire logic [2*NBEAMS-1:0] i_beam_code,
    input wire logic [7:0] i_rx_level,
    input wire logic [1:0] i_cfg_code,
    input wire logic i_cfg_restart_ilk,
    input wire logic i_cfg_cfm_en,
    input wire logic [1:0] i_cfg_diag_sel,
    input wire logic i_reset_btn,
    input wire logic i_contactor_fb,
    input wire logic i_peer_linked,
    output logic o_safety_switching_output_a,
    output logic o_safety_switching_output_b,
    output logic o_app_diag,
    output logic [7:0] o_led_blue,
    output logic [7:0] o_led_red,
    output logic [7:0] o_led_yellow,
    output logic o_rx_ssw_green,
    output logic o_rx_field_clear,
    output logic o_tx_ssw_green,
    output logic o_tx_field_clear,
    output logic o_cfm_fault,
    output logic [7:0] o_cal_ref
);
    if (NBEAMS < 2 || NBEAMS > 256 || SYNC_CYC < 1 || CAL_CYC < 1 ||
        CFM_CYC < 1 || BLINK_CYC < 1) begin : g_bad_param
        $error("lcs_top: unsupported parameter value");
    end

    lcs_pkg::lcs_state_t st_q, st_d;
    logic [31:0] sync_cnt_q, sync_cnt_d;
    logic [31:0] cal_cnt_q, cal_cnt_d;
    logic [31:0] cfm_cnt_q, cfm_cnt_d;
    logic [31:0] blink_cnt_q;
    logic blink_q;
    logic btn_q;
    logic weak_q, weak_d;
    logic cfm_fault_q, cfm_fault_d;
    logic [7:0] ref_q, ref_d;
    logic ssw_d;
    logic app_d;
    logic [7:0] blue_d, red_d, yellow_d;

    logic [NBEAMS-1:0] beam_ok;
    logic field_clear, top_ok, bot_ok;
    logic [3:0] align;

    lcs_beam_eval #(.NBEAMS(NBEAMS)) u_eval (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_beam_light(i_beam_light),
        .i_beam_code(i_beam_code),
        .i_cfg_code(i_cfg_code),
        .o_beam_ok(beam_ok),
        .o_field_clear(field_clear),
        .o_top_ok(top_ok),
        .o_bot_ok(bot_ok),
        .o_align(align)
    );

    // decode
    wire code_bad = (i_cfg_code == `LCS_CODE_ILLEGAL);
    wire sync_seen = top_ok || bot_ok;
    wire synced = sync_seen && (sync_cnt_q == SYNC_CYC);
    wire cal_end = (st_q == lcs_pkg::LCS_ST_CAL) && (cal_cnt_q == CAL_CYC - 1);
    wire press = i_reset_btn && !btn_q;
    wire blink_tick = (blink_cnt_q == BLINK_CYC - 1);
    wire in_fault = (st_q == lcs_pkg::LCS_ST_FAULT);
    wire in_lock = (st_q == lcs_pkg::LCS_ST_LOCK);
    wire in_run = (st_q == lcs_pkg::LCS_ST_RUN);
    wire cfm_wait = i_cfg_cfm_en && !o_safety_switching_output_a && !i_contactor_fb;
    wire cfm_set = cfm_wait && (cfm_cnt_q == CFM_CYC - 1);
    wire flt_leave = in_fault && press && !code_bad &&
                     (!i_cfg_cfm_en || i_contactor_fb);
    wire show_blue = !in_fault && !weak_q;
    wire [7:0] fn_cfm = 8'h01 << `LCS_LED_FUNC_CFM;
    wire [7:0] cs_cfm = 8'h01 << `LCS_LED_CAUSE_CFM;
    wire [7:0] fn_code = 8'h01 << `LCS_LED_FUNC_CODE;
    wire [7:0] cs_code = 8'h01 << `LCS_LED_CAUSE_CODE;
    wire [7:0] fn_weak = 8'h01 << `LCS_LED_FUNC_WEAK;
    wire [7:0] cs_weak = 8'h01 << `LCS_LED_CAUSE_WEAK;

    assign sync_cnt_d = (!sync_seen || (st_q != lcs_pkg::LCS_ST_SYNC)) ? 32'h0 :
                        (synced ? sync_cnt_q : sync_cnt_q + 32'h1);
    assign cal_cnt_d = (st_q == lcs_pkg::LCS_ST_CAL) ? cal_cnt_q + 32'h1 : 32'h0;
    assign cfm_cnt_d = (cfm_wait && !cfm_set) ? cfm_cnt_q + 32'h1 : 32'h0;
    // set wins over the clear on the same edge
    assign cfm_fault_d = cfm_set || (cfm_fault_q && !flt_leave);
    // largest receive level during calibration is the field reference
    assign ref_d = (st_q == lcs_pkg::LCS_ST_SYNC) ? 8'h00 :
                   ((st_q == lcs_pkg::LCS_ST_CAL) && (i_rx_level > ref_q)) ?
                   i_rx_level : ref_q;
    assign weak_d = in_run && field_clear && (i_rx_level < (ref_q >> 1));
    // outputs only on while monitoring with a clear field
    assign ssw_d = in_run && field_clear && !cfm_fault_q && !code_bad;
    assign app_d = (i_cfg_diag_sel == lcs_pkg::LCS_DIAG_RESET_REQ) ? in_lock :
                   (i_cfg_diag_sel == lcs_pkg::LCS_DIAG_WEAK) ? weak_q :
                   (i_cfg_diag_sel == lcs_pkg::LCS_DIAG_FAULT) ? in_fault :
                   !field_clear;
    assign blue_d = show_blue ? {bot_ok, bot_ok, top_ok, top_ok, align} : 8'h00;
    assign red_d = !in_fault ? 8'h00 :
                   cfm_fault_q ? (fn_cfm | (blink_q ? cs_cfm : 8'h00)) :
                   (fn_code | (blink_q ? cs_code : 8'h00));
    assign yellow_d = (!in_fault && weak_q) ?
                      (fn_weak | (blink_q ? cs_weak : 8'h00)) : 8'h00;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            lcs_pkg::LCS_ST_SYNC: begin
                if (code_bad) begin
                    st_d = lcs_pkg::LCS_ST_FAULT;
                end else if (synced) begin
                    st_d = lcs_pkg::LCS_ST_CAL;
                end
            end
            lcs_pkg::LCS_ST_CAL: begin
                if (code_bad) begin
                    st_d = lcs_pkg::LCS_ST_FAULT;
                end else if (!sync_seen) begin
                    st_d = lcs_pkg::LCS_ST_SYNC;
                end else if (cal_end) begin
                    st_d = i_cfg_restart_ilk ? lcs_pkg::LCS_ST_LOCK : lcs_pkg::LCS_ST_RUN;
                end
            end
            lcs_pkg::LCS_ST_RUN: begin
                if (code_bad || cfm_fault_q) begin
                    st_d = lcs_pkg::LCS_ST_FAULT;
                end else if (!field_clear && i_cfg_restart_ilk) begin
                    st_d = lcs_pkg::LCS_ST_LOCK;
                end
            end
            lcs_pkg::LCS_ST_LOCK: begin
                if (code_bad || cfm_fault_q) begin
                    st_d = lcs_pkg::LCS_ST_FAULT;
                end else if (press && field_clear) begin
                    st_d = lcs_pkg::LCS_ST_RUN;
                end
            end
            lcs_pkg::LCS_ST_FAULT: begin
                if (flt_leave) begin
                    st_d = lcs_pkg::LCS_ST_SYNC;
                end
            end
            default: st_d = lcs_pkg::LCS_ST_FAULT;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= lcs_pkg::LCS_ST_SYNC;
            sync_cnt_q <= 32'h0;
            cal_cnt_q <= 32'h0;
            cfm_cnt_q <= 32'h0;
            cfm_fault_q <= 1'b0;
            ref_q <= 8'h00;
            weak_q <= 1'b0;
            btn_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sync_cnt_q <= sync_cnt_d;
            cal_cnt_q <= cal_cnt_d;
            cfm_cnt_q <= cfm_cnt_d;
            cfm_fault_q <= cfm_fault_d;
            ref_q <= ref_d;
            weak_q <= weak_d;
            btn_q <= i_reset_btn;
        end
    end

    // flash rate divider
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            blink_cnt_q <= 32'h0;
            blink_q <= 1'b0;
        end else begin
            blink_cnt_q <= blink_tick ? 32'h0 : blink_cnt_q + 32'h1;
            blink_q <= blink_tick ? !blink_q : blink_q;
        end
    end

    // registered outputs
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_safety_switching_output_a <= 1'b0;
            o_safety_switching_output_b <= 1'b0;
            o_app_diag <= 1'b0;
            o_led_blue <= 8'h00;
            o_led_red <= 8'h00;
            o_led_yellow <= 8'h00;
            o_rx_ssw_green <= 1'b0;
            o_rx_field_clear <= 1'b0;
            o_tx_ssw_green <= 1'b0;
            o_tx_field_clear <= 1'b0;
            o_cfm_fault <= 1'b0;
            o_cal_ref <= 8'h00;
        end else begin
            o_safety_switching_output_a <= ssw_d;
            o_safety_switching_output_b <= ssw_d;
            o_app_diag <= app_d;
            o_led_blue <= blue_d;
            o_led_red <= red_d;
            o_led_yellow <= yellow_d;
            o_rx_ssw_green <= ssw_d;
            o_rx_field_clear <= field_clear;
            o_tx_ssw_green <= i_peer_linked && ssw_d;
            o_tx_field_clear <= i_peer_linked && field_clear;
            o_cfm_fault <= cfm_fault_d;
            o_cal_ref <= ref_q;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    AST_TRIP: assert property (!field_clear |=> !o_safety_switching_output_a &&
        !o_safety_switching_output_b)
        else $error("outputs on with an interrupted beam");
    AST_SYNC_BEFORE_CAL: assert property (
        (st_q == lcs_pkg::LCS_ST_SYNC) && (st_d == lcs_pkg::LCS_ST_CAL) |-> synced && sync_seen)
        else $error("calibration started without optical sync");
    AST_CAL_FIRST: assert property (
        $rose(o_safety_switching_output_a) |-> $past(in_run) && (cal_cnt_q == 32'h0))
        else $error("outputs on before calibration and run");
    AST_ILLEGAL_CODE: assert property (code_bad |-> ##2 !o_safety_switching_output_a)
        else $error("illegal coding left outputs on");
    AST_ALIGN: assert property (show_blue |=> o_led_blue[3:0] == $past(align))
        else $error("alignment indicators wrong");
    AST_TOP_BEAM: assert property (show_blue && top_ok |=> o_led_blue[5:4] == 2'b11)
        else $error("top beam indicators not lit");
    AST_BOT_BEAM: assert property (show_blue && bot_ok |=> o_led_blue[7:6] == 2'b11)
        else $error("bottom beam indicators not lit");
    AST_INTERLOCK: assert property (
        in_run && i_cfg_restart_ilk && !field_clear && !code_bad && !cfm_fault_q |=>
        in_lock ##1 (!o_safety_switching_output_a [*2]))
        else $error("interlock did not hold outputs off");
    AST_CFM_SET: assert property (cfm_set |=> cfm_fault_q ##1 !o_safety_switching_output_a)
        else $error("contactor timeout not reported");
    AST_CFM_HOLD: assert property (cfm_fault_q |=> !o_safety_switching_output_a)
        else $error("outputs on during contactor fault");
    AST_APP_DIAG: assert property (
        (i_cfg_diag_sel == lcs_pkg::LCS_DIAG_FAULT) |=> o_app_diag == $past(in_fault))
        else $error("diagnostic output does not follow fault");
    AST_TX_IND: assert property (!i_peer_linked |=> !o_tx_ssw_green && !o_tx_field_clear)
        else $error("sender indicators lit without link");
    AST_RX_IND: assert property (o_rx_ssw_green == o_safety_switching_output_a)
        else $error("receiver output indicator disagrees with outputs");
    AST_FAULT_LED: assert property (
        in_fault && cfm_fault_q |=> o_led_red[`LCS_LED_FUNC_CFM] &&
        (o_led_red[`LCS_LED_CAUSE_CFM] == $past(blink_q)))
        else $error("fault indicators wrong");
    AST_WARN_LED: assert property (
        !in_fault && weak_q |=> o_led_yellow[`LCS_LED_FUNC_WEAK] && o_led_blue == 8'h00)
        else $error("warning indicators wrong");

    COV_RUN_ON: cover property ($rose(o_safety_switching_output_a));
    COV_LOCK_RELEASE: cover property (in_lock ##1 in_run);
    COV_CFM_FAULT: cover property (cfm_set);
    COV_WEAK: cover property ($rose(weak_q));

endmodule
`default_nettype wire

// ### tb/lcs_machine_model.sv
// machine side model: positively guided contactors behind the safety outputs
`timescale 1ns/1ps
`default_nettype none
module lcs_machine_model (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ssw_a,
    input wire logic i_ssw_b,
    input wire logic i_stuck,
    output var logic o_fb
);
    logic [1:0] drop_q;
    // contactors drop two cycles after either channel goes off
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            drop_q <= 2'h3;
        end else begin
            drop_q <= {drop_q[0], ~(i_ssw_a & i_ssw_b)};
        end
    end
    // a welded contact never reports drop-out
    assign o_fb = drop_q[1] & ~i_stuck;
endmodule
`default_nettype wire

// ### tb/lcs_top_tb.sv
// self-checking bench of the light curtain supervisory logic
`timescale 1ns/1ps
`default_nettype none
module lcs_top_tb;
    localparam int NB = 4;
    logic clk = 0, rst = 1, ilk = 0, cfm = 0, btn = 0, peer = 0, stuck = 0, fb;
    logic [NB-1:0] light = '1;
    logic [2*NB-1:0] code = '0;
    logic [7:0] lvl = 8'h80, ref8;
    logic [1:0] cfg = 2'h0, dsel = 2'h3;
    logic sa, sb, diag, rxg, rxf, txg, txf, cflt;
    logic [7:0] blue, red, yel, cref;
    logic [31:0] seed = 32'hb7ea;
    int bad_count = 0, checks_done = 0;
    int q[$];
    initial forever #5 clk = ~clk;
    lcs_top #(.NBEAMS(NB), .SYNC_CYC(4), .CAL_CYC(4), .CFM_CYC(8), .BLINK_CYC(4)) dut (
        .i_core_clk(clk), .i_rst(rst), .i_beam_light(light), .i_beam_code(code),
        .i_rx_level(lvl), .i_cfg_code(cfg), .i_cfg_restart_ilk(ilk), .i_cfg_cfm_en(cfm),
        .i_cfg_diag_sel(dsel), .i_reset_btn(btn), .i_contactor_fb(fb), .i_peer_linked(peer),
        .o_safety_switching_output_a(sa), .o_safety_switching_output_b(sb),
        .o_app_diag(diag), .o_led_blue(blue), .o_led_red(red), .o_led_yellow(yel),
        .o_rx_ssw_green(rxg), .o_rx_field_clear(rxf), .o_tx_ssw_green(txg),
        .o_tx_field_clear(txf), .o_cfm_fault(cflt), .o_cal_ref(cref));
    lcs_machine_model mach (.i_core_clk(clk), .i_rst(rst), .i_ssw_a(sa), .i_ssw_b(sb),
        .i_stuck(stuck), .o_fb(fb));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // poll one design flag until it reaches v, bounded
    task automatic wait_bit(int which, logic v);
        logic s;
        for (int i = 0; i < 300; i++) begin
            tick(1);
            s = (which == 0) ? sa : (which == 1) ? cflt : red[2];
            if (s === v) return;
        end
        bad_count++;
        $display("wrong value wait %0d expected %b seen timeout", which, v);
        summarize();
    endtask
    task automatic press();
        @(posedge clk);
        btn <= 1'b1;
        tick(4);
        @(posedge clk);
        btn <= 1'b0;
        tick(1);
    endtask
    // reset then power-up with a fixed receive level for calibration
    task automatic start(logic [1:0] c, logic il);
        @(posedge clk);
        rst <= 1'b1;
        cfg <= c;
        ilk <= il;
        code <= {NB{c}};
        light <= '1;
        peer <= 1'(rnd());
        lvl <= 8'h80 | (8'(rnd()) & 8'h7f);
        tick(20);
        chk("ssw in reset", {sa, sb, rxg, cflt}, 4'h0);
        @(posedge clk);
        rst <= 1'b0;
        ref8 = lvl;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            chk("ssw before calibration", {sa, sb}, 2'h0);
        end
    endtask
    task automatic run_ok();
        wait_bit(0, 1'b1);
        chk("ssw b", sb, 1'b1);
        chk("cal ref", cref, ref8);
        chk("rx leds", {rxg, rxf}, 2'h3);
        chk("tx leds", {txg, txf}, {2{peer}});
        chk("blue", blue, 8'hff);
    endtask
    initial begin
        tick(1);
        for (int c = 0; c < 3; c++) begin
            start(c[1:0], 1'b0);
            run_ok();
        end
        // random beam loss and code mismatch, compared with a 2-cycle model
        @(posedge clk);
        dsel <= 2'h3;
        for (int i = 0; i < 200; i++) begin
            logic [NB-1:0] l;
            logic [2*NB-1:0] k;
            int e;
            @(posedge clk);
            l = (rnd() % 3 == 0) ? NB'(rnd()) : '1;
            k = (rnd() % 5 == 0) ? (2*NB)'(rnd()) : {NB{cfg}};
            light <= l;
            code <= k;
            e = 1;
            for (int b = 0; b < NB; b++) begin
                if (!l[b] || k[2*b+:2] != cfg) e = 0;
            end
            q.push_back(e);
            #1;
            if (q.size() > 2) begin
                chk("ssw follows field", sa, q[0][0]);
                chk("diag interrupted", diag, !q[0][0]);
                void'(q.pop_front());
            end
        end
        @(posedge clk);
        light <= {1'b0, {NB-1{1'b1}}};
        code <= {NB{cfg}};
        tick(3);
        chk("blue top lost", blue, 8'hc7);
        @(posedge clk);
        light <= {{NB-1{1'b1}}, 1'b0};
        tick(3);
        chk("blue bottom lost", blue, 8'h37);
        // weak signal warning
        @(posedge clk);
        light <= '1;
        dsel <= 2'h1;
        lvl <= (ref8 >> 1) - 8'h01;
        tick(5);
        chk("weak yellow", yel[1], 1'b1);
        chk("weak diag", diag, 1'b1);
        // restart interlock at power-up and after a trip
        start(2'h1, 1'b1);
        @(posedge clk);
        dsel <= 2'h0;
        tick(30);
        chk("locked ssw", sa, 1'b0);
        chk("diag reset req", diag, 1'b1);
        press();
        chk("ssw after press", sa, 1'b1);
        @(posedge clk);
        light <= 4'h6;
        tick(3);
        press();
        chk("press while blocked", sa, 1'b0);
        @(posedge clk);
        light <= '1;
        tick(10);
        chk("no restart", sa, 1'b0);
        press();
        chk("restart", sa, 1'b1);
        // contactor monitoring: good drop-out then a welded contact
        start(2'h2, 1'b0);
        @(posedge clk);
        cfm <= 1'b1;
        dsel <= 2'h2;
        run_ok();
        @(posedge clk);
        light <= '0;
        tick(20);
        chk("no cfm fault", cflt, 1'b0);
        @(posedge clk);
        light <= '1;
        wait_bit(0, 1'b1);
        @(posedge clk);
        stuck <= 1'b1;
        light <= 4'hb;
        wait_bit(1, 1'b1);
        @(posedge clk);
        light <= '1;
        tick(4);
        chk("fault red led1", red[0], 1'b1);
        chk("fault holds off", sa, 1'b0);
        chk("fault diag", diag, 1'b1);
        @(posedge clk);
        stuck <= 1'b0;
        tick(4);
        press();
        run_ok();
        // illegal coding is a fault
        start(2'h3, 1'b0);
        wait_bit(2, 1'b1);
        chk("illegal code ssw", sa, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
